/* shared/spfa_pkg.sv */
/*
  constants for the self_programming flash access block: register offsets,
  field positions, mode codes, reset values and timing counts.
  assumes a 32-bit classic wishbone register bus with word-aligned offsets.
*/
package spfa_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [5:0] SPFA_OFS_MAIN_CTRL = 6'h00;
  localparam logic [5:0] SPFA_OFS_RST_PAT = 6'h04;
  localparam logic [5:0] SPFA_OFS_BUF_CLR = 6'h08;
  localparam logic [5:0] SPFA_OFS_ADDR_LO = 6'h0C;
  localparam logic [5:0] SPFA_OFS_ADDR_HI = 6'h10;
  localparam logic [5:0] SPFA_OFS_D0_LO = 6'h14;
  localparam logic [5:0] SPFA_OFS_D0_HI = 6'h18;
  localparam logic [5:0] SPFA_OFS_D1_LO = 6'h1C;
  localparam logic [5:0] SPFA_OFS_D1_HI = 6'h20;
  localparam logic [5:0] SPFA_OFS_D2_LO = 6'h24;
  localparam logic [5:0] SPFA_OFS_D2_HI = 6'h28;
  localparam logic [5:0] SPFA_OFS_D3_LO = 6'h2C;
  localparam logic [5:0] SPFA_OFS_D3_HI = 6'h30;
  // ----------------------------------------
  // main control field positions, buffer clear bit and address high width
  // ----------------------------------------
  localparam int SPFA_BIT_EW_FLAG = 7;
  localparam int SPFA_BIT_MODE_HI = 6;
  localparam int SPFA_BIT_MODE_LO = 4;
  localparam int SPFA_BIT_EN_TRIG = 3;
  localparam int SPFA_BIT_WR_START = 2;
  localparam int SPFA_BIT_RD_EN = 1;
  localparam int SPFA_BIT_RD_START = 0;
  localparam int SPFA_BIT_BUF_CLR = 0;
  localparam int SPFA_ADDR_HI_BITS = 5;
  // ----------------------------------------
  // operation mode codes
  // ----------------------------------------
  localparam logic [2:0] SPFA_MODE_WRITE = 3'h0;
  localparam logic [2:0] SPFA_MODE_ERASE = 3'h1;
  localparam logic [2:0] SPFA_MODE_READ = 3'h3;
  localparam logic [2:0] SPFA_MODE_ENABLE = 3'h6;
  // ----------------------------------------
  // reset values and geometry
  // ----------------------------------------
  localparam logic [7:0] SPFA_RST_BYTE = 8'h00;
  localparam logic [15:0] SPFA_RST_WORD = 16'h0000;
  localparam logic [15:0] SPFA_BUF_BLANK = 16'hFFFF;
  localparam int SPFA_PAGE_WORDS = 32;
  localparam int SPFA_ADDR_W = 13;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SPFA_CLK_HZ = 25_000_000;
  localparam int SPFA_EN_WIN_US = 100;
  localparam int SPFA_EN_WIN_CYC = SPFA_EN_WIN_US * (SPFA_CLK_HZ / 1_000_000);
  localparam int SPFA_CLR_CYC = SPFA_PAGE_WORDS;
  localparam int SPFA_RD_CYC = 4;
  // ----------------------------------------
  // unlock pattern defaults, arbitrary values
  // ----------------------------------------
  localparam logic [15:0] SPFA_PAT1 = 16'hA55A;
  localparam logic [15:0] SPFA_PAT2 = 16'h3CC3;
  localparam logic [15:0] SPFA_PAT3 = 16'h0FF0;
endpackage

/* design/spfa_flash_port.sv */
/*
  flash array front end: one-word read and timed page erase or page program.
  assumes a single clock; the array model behind it is abstract storage.
*/
`timescale 1ns/1ps
module spfa_flash_port
  import spfa_pkg::*;
#(
  parameter int PROG_CYC = 1000,
  parameter int ERASE_CYC = 2000
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_rd,
  input wire logic i_erase,
  input wire logic i_prog,
  input wire logic [12:0] i_addr,
  input wire logic [SPFA_PAGE_WORDS*16-1:0] i_page,
  output logic o_done,
  output logic [15:0] o_rd_data
);
  initial begin
    if (PROG_CYC < 1 || ERASE_CYC < 1) begin
      $error("spfa_flash_port: cycle counts must be at least one");
    end
  end

  // ----------------------------------------
  // array storage
  // ----------------------------------------
  logic [15:0] mem [0:(1<<SPFA_ADDR_W)-1];
  logic [31:0] cnt_q;
  logic busy_q;
  logic prog_q;
  logic [12:0] addr_q;
  logic rd_q;

  always_ff @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      prog_q <= 1'b0;
      addr_q <= 13'h0;
      rd_q <= 1'b0;
      o_rd_data <= SPFA_RST_WORD;
    end else if (!busy_q) begin
      if (i_rd) begin
        busy_q <= 1'b1;
        prog_q <= 1'b0;
        addr_q <= i_addr;
        rd_q <= 1'b1;
        cnt_q <= 32'(SPFA_RD_CYC);
      end else if (i_erase || i_prog) begin
        busy_q <= 1'b1;
        prog_q <= i_prog;
        rd_q <= 1'b0;
        addr_q <= {i_addr[12:5], 5'h00};
        cnt_q <= i_prog ? 32'(PROG_CYC) : 32'(ERASE_CYC);
      end
    end else if (cnt_q > 32'h1) begin
      cnt_q <= cnt_q - 32'h1;
    end else begin
      busy_q <= 1'b0;
      o_done <= 1'b1;
      if (rd_q) begin
        o_rd_data <= mem[addr_q];
      end
    end
  end

  // program ands into cells, as a real array only pulls bits low
  always_ff @(posedge i_ref_clk) begin
    if (busy_q && cnt_q == 32'h1) begin
      // whole page per erase or program
      for (int w = 0; w < SPFA_PAGE_WORDS; w++) begin
        if (prog_q) begin
          mem[{addr_q[12:5], 5'(w)}] <= mem[{addr_q[12:5], 5'(w)}] & i_page[w*16 +: 16];
        end else if (!rd_q) begin
          mem[{addr_q[12:5], 5'(w)}] <= SPFA_BUF_BLANK;
        end
      end
    end
  end
endmodule

/* design/spfa_core.sv */
/*
  self_programming flash access register block with page write buffer.
  assumes a classic wishbone master on the same clock; the cpu watches
  o_cpu_stall and holds off while an array operation runs.
*/
// Function
// - erase and program act on 32-word pages; a read returns one word.
// - enabled flag set on successful unlock; buffer loads only while it is high.
// - write-start bit stays high during the write, cleared by hardware at finish.
// - read needs read-enable; read-start bit cleared when the word read completes.
// - buffer-clear bit starts a clear and returns to zero when done.
// - buffer maps to page chosen by address bits 12:5; low five index words.
// - writing data word 0 low only updates that register.
// - writing data word 0 high loads the 16-bit word into the buffer.
// - each buffer load below word offset 31 increments the address and writes it back.
// - at word offset 31 the address holds, with no wrap.
// - the buffer is cleared automatically after a program (mode 000) finishes, not after an erase.
// - address high keeps bits 12:8 only; upper three bits read zero.
// - all registers in one sector; transfers use 16-bit words.
// - mode field: 000 write, 001 erase, 011 read, 110 enable; rest reserved.
// - enable trigger starts a timer, cleared on timeout; patterns go in pairs 1-3.
// - enabled flag only hardware-set; software writing one does nothing, zero disables.
// - the processor stalls during any started read, erase or write.
`timescale 1ns/1ps
module spfa_core
  import spfa_pkg::*;
#(
  parameter int EN_WIN_CYC = SPFA_EN_WIN_CYC,
  parameter int PROG_CYC = 1000,
  parameter int ERASE_CYC = 2000,
  parameter logic [15:0] PAT1 = SPFA_PAT1,
  parameter logic [15:0] PAT2 = SPFA_PAT2,
  parameter logic [15:0] PAT3 = SPFA_PAT3
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_cpu_stall,
  output logic o_chip_reset
);
  initial begin
    if (EN_WIN_CYC < 1 || EN_WIN_CYC > 32'h00FF_FFFF) begin
      $error("spfa_core: enable window out of range");
    end
    if (SPFA_PAGE_WORDS != (1 << 5) || SPFA_CLR_CYC >= (1 << 6)) begin
      $error("spfa_core: buffer geometry does not fit the word index");
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_ERASE, ST_PROG, ST_CLEAR} spfa_op_e;

  typedef struct packed {
    logic ew_flag;
    logic [2:0] mode;
    logic en_trig;
    logic wr_start;
    logic rd_en;
    logic rd_start;
    logic buf_clr;
    logic [7:0] rst_pat;
    logic [12:0] addr;
    logic [7:0][7:0] dat;
    logic [23:0] win_cnt;
    logic [5:0] clr_cnt;
    spfa_op_e op;
    logic go_rd;
    logic go_erase;
    logic go_prog;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic stall;
    logic chip_reset;
  } spfa_state_s;

  spfa_state_s s_q;
  spfa_state_s s_d;
  logic [15:0] wbuf_q [0:SPFA_PAGE_WORDS-1];
  logic [SPFA_PAGE_WORDS*16-1:0] page_flat;
  logic done;
  logic [15:0] rd_word;
  logic buf_load;
  logic buf_wipe;
  logic [4:0] buf_idx;

  function automatic logic [7:0] byte_of(input logic [31:0] d);
    return d[7:0];
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] wv;
    logic [7:0] rv;
    wr = 1'b0;
    rd = 1'b0;
    wv = 8'h00;
    rv = 8'h00;
    s_d = s_q;
    s_d.wb_ack = 1'b0;
    s_d.go_rd = 1'b0;
    s_d.go_erase = 1'b0;
    s_d.go_prog = 1'b0;
    s_d.chip_reset = 1'b0;
    buf_load = 1'b0;
    buf_wipe = 1'b0;
    buf_idx = s_q.addr[4:0];
    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // single-cycle answer; ack drops the cycle after it rose
    if (i_wb_cyc && i_wb_stb && !s_q.wb_ack) begin
      s_d.wb_ack = 1'b1;
      wr = i_wb_we && i_wb_sel[0];
      rd = !i_wb_we;
    end
    wv = byte_of(i_wb_dat);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr) begin
      case (i_wb_adr)
        SPFA_OFS_MAIN_CTRL: begin
          // flag can only be cleared by software
          if (!wv[SPFA_BIT_EW_FLAG]) begin
            s_d.ew_flag = 1'b0;
          end
          if (s_q.op == ST_IDLE) begin
            s_d.mode = wv[SPFA_BIT_MODE_HI:SPFA_BIT_MODE_LO];
            s_d.rd_en = wv[SPFA_BIT_RD_EN];
            if (wv[SPFA_BIT_EN_TRIG] && !s_q.en_trig) begin
              s_d.en_trig = 1'b1;
              s_d.win_cnt = 24'(EN_WIN_CYC - 1);
            end
            // start requests are refused unless mode and enables fit
            if (wv[SPFA_BIT_WR_START] && s_q.ew_flag && !wv[SPFA_BIT_RD_START]) begin
              if (wv[SPFA_BIT_MODE_HI:SPFA_BIT_MODE_LO] == SPFA_MODE_WRITE) begin
                s_d.wr_start = 1'b1;
                s_d.op = ST_PROG;
                s_d.go_prog = 1'b1;
                s_d.stall = 1'b1;
              end else if (wv[SPFA_BIT_MODE_HI:SPFA_BIT_MODE_LO] == SPFA_MODE_ERASE) begin
                s_d.wr_start = 1'b1;
                s_d.op = ST_ERASE;
                s_d.go_erase = 1'b1;
                s_d.stall = 1'b1;
              end
            end else if (wv[SPFA_BIT_RD_START] && s_q.rd_en
                         && wv[SPFA_BIT_MODE_HI:SPFA_BIT_MODE_LO] == SPFA_MODE_READ) begin
              s_d.rd_start = 1'b1;
              s_d.op = ST_READ;
              s_d.go_rd = 1'b1;
              s_d.stall = 1'b1;
            end
          end
        end
        SPFA_OFS_RST_PAT: begin
          s_d.rst_pat = wv;
          s_d.chip_reset = (wv == 8'h55);
        end
        SPFA_OFS_BUF_CLR: begin
          if (wv[SPFA_BIT_BUF_CLR] && s_q.op == ST_IDLE) begin
            s_d.buf_clr = 1'b1;
            s_d.op = ST_CLEAR;
            s_d.clr_cnt = 6'(SPFA_CLR_CYC);
          end
        end
        SPFA_OFS_ADDR_LO: s_d.addr[7:0] = wv;
        SPFA_OFS_ADDR_HI: s_d.addr[12:8] = wv[SPFA_ADDR_HI_BITS-1:0];
        SPFA_OFS_D0_LO: s_d.dat[0] = wv;
        SPFA_OFS_D0_HI: begin
          s_d.dat[1] = wv;
          if (s_q.ew_flag && s_q.op == ST_IDLE) begin
            buf_load = 1'b1;
            // hold at the last word of the page
            if (s_q.addr[4:0] != 5'h1F) begin
              s_d.addr = s_q.addr + 13'h1;
            end
          end
        end
        SPFA_OFS_D1_LO: s_d.dat[2] = wv;
        SPFA_OFS_D1_HI: s_d.dat[3] = wv;
        SPFA_OFS_D2_LO: s_d.dat[4] = wv;
        SPFA_OFS_D2_HI: s_d.dat[5] = wv;
        SPFA_OFS_D3_LO: s_d.dat[6] = wv;
        SPFA_OFS_D3_HI: s_d.dat[7] = wv;
        default: ;
      endcase
    end

    // ----------------------------------------
    // unlock window
    // ----------------------------------------
    // after the writes, so a hardware set beats a software clear
    if (s_q.en_trig) begin
      if (s_q.win_cnt == 24'h0) begin
        s_d.en_trig = 1'b0;
      end else begin
        s_d.win_cnt = s_q.win_cnt - 24'h1;
      end
      if ({s_q.dat[3], s_q.dat[2]} == PAT1 && {s_q.dat[5], s_q.dat[4]} == PAT2
          && {s_q.dat[7], s_q.dat[6]} == PAT3 && s_q.mode == SPFA_MODE_ENABLE) begin
        s_d.ew_flag = 1'b1;
        s_d.en_trig = 1'b0;
      end
    end
    // ----------------------------------------
    // operation sequencing
    // ----------------------------------------
    case (s_q.op)
      ST_IDLE: ;
      ST_READ: begin
        if (done) begin
          s_d.dat[0] = rd_word[7:0];
          s_d.dat[1] = rd_word[15:8];
          s_d.rd_start = 1'b0;
          s_d.stall = 1'b0;
          s_d.op = ST_IDLE;
        end
      end
      ST_ERASE, ST_PROG: begin
        if (done) begin
          s_d.wr_start = 1'b0;
          s_d.stall = 1'b0;
          if (s_q.op == ST_PROG) begin
            buf_wipe = 1'b1;
          end
          s_d.op = ST_IDLE;
        end
      end
      ST_CLEAR: begin
        // one word per cycle keeps the clear to a single write port
        buf_idx = 5'(s_q.clr_cnt - 6'h1);
        if (s_q.clr_cnt == 6'h1) begin
          s_d.buf_clr = 1'b0;
          s_d.op = ST_IDLE;
        end
        s_d.clr_cnt = s_q.clr_cnt - 6'h1;
      end
      default: s_d.op = ST_IDLE;
    endcase

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // unmapped offsets read zero; writes there are dropped
    if (rd) begin
      case (i_wb_adr)
        SPFA_OFS_MAIN_CTRL: rv = {s_q.ew_flag, s_q.mode, s_q.en_trig, s_q.wr_start,
                                  s_q.rd_en, s_q.rd_start};
        SPFA_OFS_RST_PAT: rv = s_q.rst_pat;
        SPFA_OFS_BUF_CLR: rv = {7'h00, s_q.buf_clr};
        SPFA_OFS_ADDR_LO: rv = s_q.addr[7:0];
        SPFA_OFS_ADDR_HI: rv = {3'h0, s_q.addr[12:8]};
        SPFA_OFS_D0_LO: rv = s_q.dat[0];
        SPFA_OFS_D0_HI: rv = s_q.dat[1];
        SPFA_OFS_D1_LO: rv = s_q.dat[2];
        SPFA_OFS_D1_HI: rv = s_q.dat[3];
        SPFA_OFS_D2_LO: rv = s_q.dat[4];
        SPFA_OFS_D2_HI: rv = s_q.dat[5];
        SPFA_OFS_D3_LO: rv = s_q.dat[6];
        SPFA_OFS_D3_HI: rv = s_q.dat[7];
        default: rv = 8'h00;
      endcase
      s_d.wb_dat = {24'h000000, rv};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // write buffer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || buf_wipe) begin
      for (int w = 0; w < SPFA_PAGE_WORDS; w++) begin
        wbuf_q[w] <= SPFA_BUF_BLANK;
      end
    end else if (buf_load) begin
      wbuf_q[buf_idx] <= {byte_of(i_wb_dat), s_q.dat[0]};
    end else if (s_q.op == ST_CLEAR) begin
      wbuf_q[buf_idx] <= SPFA_BUF_BLANK;
    end
  end

  // ----------------------------------------
  // buffer flattening
  // ----------------------------------------
  always_comb begin
    for (int w = 0; w < SPFA_PAGE_WORDS; w++) begin
      page_flat[w*16 +: 16] = wbuf_q[w];
    end
  end

  spfa_flash_port #(
    .PROG_CYC(PROG_CYC),
    .ERASE_CYC(ERASE_CYC)
  ) u_port (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rd(s_q.go_rd),
    .i_erase(s_q.go_erase),
    .i_prog(s_q.go_prog),
    .i_addr(s_q.addr),
    .i_page(page_flat),
    .o_done(done),
    .o_rd_data(rd_word)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_wb_dat = s_q.wb_dat;
  assign o_wb_ack = s_q.wb_ack;
  assign o_cpu_stall = s_q.stall;
  assign o_chip_reset = s_q.chip_reset;
endmodule

/* bench/spfa_core_checker.sv */
/*
  checker for spfa_core: bus handshake, read masks, reset pattern, stall span.
  assumes it is bound to spfa_core and sees only its ports.
*/
`timescale 1ns/1ps
module spfa_core_checker
  import spfa_pkg::*;
#(
  parameter int PROG_CYC = 1000,
  parameter int ERASE_CYC = 2000
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_cpu_stall,
  input wire logic o_chip_reset
);
  // ----
  // helpers
  // ----
  logic [15:0] stall_cnt_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !o_cpu_stall) begin
      stall_cnt_q <= 16'h0000;
    end else begin
      stall_cnt_q <= stall_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd_ack;
    o_wb_ack && !i_wb_we;
  endsequence
  sequence s_pat_wr;
    s_take ##0 (i_wb_we && i_wb_sel[0] && i_wb_adr == SPFA_OFS_RST_PAT
      && i_wb_dat[7:0] == 8'h55);
  endsequence
  // ----
  // assertions
  // ----
  chk_ack_latency: assert property (s_take |=> o_wb_ack)
    else $error("ack did not follow a request by one cycle");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  chk_ack_no_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without a request");
  chk_rd_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_addr_hi_bits: assert property (s_rd_ack ##0 (i_wb_adr == SPFA_OFS_ADDR_HI)
    |-> o_wb_dat[7:5] == 3'h0)
    else $error("address high unimplemented bits not zero");
  chk_clr_reg_bits: assert property (s_rd_ack ##0 (i_wb_adr == SPFA_OFS_BUF_CLR)
    |-> o_wb_dat[7:1] == 7'h00)
    else $error("buffer clear register upper bits not zero");
  chk_reset_trigger: assert property (s_pat_wr |-> ##[1:3] o_chip_reset)
    else $error("reset pattern gave no chip reset pulse");
  chk_reset_pulse: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset longer than one cycle");
  chk_stall_bound: assert property (stall_cnt_q <= ERASE_CYC + 8)
    else $error("stall outlasted the longest operation");
endmodule

/* bench/tb_spfa_core.sv */
/*
  bench for spfa_core: register table, unlock, page load, erase, program, read.
  assumes spfa_pkg and the checker are compiled before this file.
*/
`timescale 1ns/1ps
module tb_spfa_core
  import spfa_pkg::*;
;
  localparam int PROG_CYC = 10;
  localparam int ERASE_CYC = 20;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} spfa_row_s;
  logic i_ref_clk, i_srst, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [5:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic o_wb_ack, o_cpu_stall, o_chip_reset;
  logic [7:0] q, lo;
  int fail_count = 0;
  int samples_checked = 0;
  int pulses = 0;
  int stalls = 0;
  logic [7:0] raddr [3] = '{8'h1E, 8'h1F, 8'h00};
  logic [15:0] rexp [3] = '{16'h1234, 16'h5678, 16'hFFFF};
  spfa_row_s rows [11] = '{
    '{SPFA_OFS_ADDR_LO, 8'hA5, 8'hA5}, '{SPFA_OFS_ADDR_HI, 8'hFF, 8'h1F},
    '{SPFA_OFS_D0_LO, 8'h3C, 8'h3C}, '{SPFA_OFS_D0_HI, 8'hC3, 8'hC3},
    '{SPFA_OFS_D1_LO, 8'h11, 8'h11}, '{SPFA_OFS_D1_HI, 8'h22, 8'h22},
    '{SPFA_OFS_D2_LO, 8'h33, 8'h33}, '{SPFA_OFS_D2_HI, 8'h44, 8'h44},
    '{SPFA_OFS_D3_LO, 8'h5A, 8'h5A}, '{SPFA_OFS_MAIN_CTRL, 8'h80, 8'h00},
    '{6'h3C, 8'hFF, 8'h00}};
  spfa_core #(.EN_WIN_CYC(50), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_cpu_stall(o_cpu_stall),
    .o_chip_reset(o_chip_reset));
  // ----
  // clock, monitors, tasks
  // ----
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // counted in the background so short pulses are never missed between bus cycles
  always @(posedge i_ref_clk) begin
    if (o_chip_reset === 1'b1) pulses++;
    if (o_cpu_stall === 1'b1) stalls++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h000000, d};
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) check(16'h0001, 16'h0000);
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  // cpu holds off the bus while stalled, so wait for the stall to end first
  task automatic start_op(input logic [7:0] d, input logic exp);
    int s0;
    s0 = stalls;
    wr(SPFA_OFS_MAIN_CTRL, d);
    for (int n = 0; n < 400; n++) begin
      @(posedge i_ref_clk);
      if (n > 8 && o_cpu_stall === 1'b0) break;
    end
    check({15'h0000, stalls > s0}, {15'h0000, exp});
    check({15'h0000, o_cpu_stall}, 16'h0000);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    check(16'h0001, 16'h0000);
    finish_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    i_srst = 1'b1;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 6'h00;
    i_wb_sel = 4'h1;
    i_wb_dat = 32'h00000000;
    repeat (20) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    for (int a = 0; a <= 48; a += 4) begin
      rd(6'(a));
      check({8'h00, q}, 16'h0000);
    end
    $display("reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      check({8'h00, q}, {8'h00, rows[i].e});
    end
    check(16'(pulses), 16'h0000);
    $display("register table done");
    wr(SPFA_OFS_ADDR_HI, 8'h00);
    wr(SPFA_OFS_ADDR_LO, 8'h1E);
    wr(SPFA_OFS_D0_HI, 8'h12);
    rd(SPFA_OFS_ADDR_LO);
    check({8'h00, q}, 16'h001E);
    wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_ENABLE, 4'h8});
    wr(SPFA_OFS_D1_LO, SPFA_PAT1[7:0]);
    wr(SPFA_OFS_D1_HI, SPFA_PAT1[15:8]);
    wr(SPFA_OFS_D2_LO, SPFA_PAT2[7:0]);
    wr(SPFA_OFS_D2_HI, SPFA_PAT2[15:8]);
    wr(SPFA_OFS_D3_LO, SPFA_PAT3[7:0]);
    wr(SPFA_OFS_D3_HI, SPFA_PAT3[15:8]);
    repeat (60) @(posedge i_ref_clk);
    rd(SPFA_OFS_MAIN_CTRL);
    check({8'h00, q & 8'h88}, 16'h0080);
    $display("unlock done");
    start_op({1'b1, SPFA_MODE_ERASE, 4'h4}, 1'b1);
    rd(SPFA_OFS_MAIN_CTRL);
    check({15'h0000, q[SPFA_BIT_WR_START]}, 16'h0000);
    wr(SPFA_OFS_BUF_CLR, 8'h01);
    for (int n = 0; n < 40; n++) begin
      rd(SPFA_OFS_BUF_CLR);
      if (q === 8'h00) break;
    end
    check({8'h00, q}, 16'h0000);
    wr(SPFA_OFS_D0_LO, 8'h34);
    rd(SPFA_OFS_ADDR_LO);
    check({8'h00, q}, 16'h001E);
    wr(SPFA_OFS_D0_HI, 8'h12);
    rd(SPFA_OFS_ADDR_LO);
    check({8'h00, q}, 16'h001F);
    wr(SPFA_OFS_D0_LO, 8'h78);
    wr(SPFA_OFS_D0_HI, 8'h56);
    rd(SPFA_OFS_ADDR_LO);
    check({8'h00, q}, 16'h001F);
    start_op({1'b1, SPFA_MODE_WRITE, 4'h4}, 1'b1);
    rd(SPFA_OFS_MAIN_CTRL);
    check({15'h0000, q[SPFA_BIT_WR_START]}, 16'h0000);
    $display("erase and program done");
    wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_READ, 4'h0});
    start_op({1'b0, SPFA_MODE_READ, 4'h1}, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(SPFA_OFS_ADDR_LO, raddr[i]);
      wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_READ, 4'h2});
      start_op({1'b0, SPFA_MODE_READ, 4'h3}, 1'b1);
      rd(SPFA_OFS_MAIN_CTRL);
      check({15'h0000, q[SPFA_BIT_RD_START]}, 16'h0000);
      rd(SPFA_OFS_D0_LO);
      lo = q;
      rd(SPFA_OFS_D0_HI);
      check({q, lo}, rexp[i]);
    end
    $display("read back done");
    wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_ENABLE, 4'h8});
    start_op({1'b1, SPFA_MODE_ERASE, 4'h4}, 1'b1);
    start_op({1'b1, SPFA_MODE_WRITE, 4'h4}, 1'b1);
    start_op({1'b1, 3'h2, 4'h4}, 1'b0);
    wr(SPFA_OFS_ADDR_LO, 8'h1E);
    wr(SPFA_OFS_D0_LO, 8'h00);
    wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_READ, 4'h2});
    start_op({1'b0, SPFA_MODE_READ, 4'h3}, 1'b1);
    rd(SPFA_OFS_D0_LO);
    lo = q;
    rd(SPFA_OFS_D0_HI);
    check({q, lo}, 16'hFFFF);
    wr(SPFA_OFS_D1_LO, 8'h00);
    wr(SPFA_OFS_MAIN_CTRL, {1'b0, SPFA_MODE_ENABLE, 4'h8});
    rd(SPFA_OFS_MAIN_CTRL);
    check({8'h00, q & 8'h88}, 16'h0008);
    repeat (60) @(posedge i_ref_clk);
    rd(SPFA_OFS_MAIN_CTRL);
    check({8'h00, q & 8'h88}, 16'h0000);
    $display("rewrite and unlock timeout done");
    wr(SPFA_OFS_RST_PAT, 8'h55);
    repeat (3) @(posedge i_ref_clk);
    check(16'(pulses), 16'h0001);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    rd(SPFA_OFS_D0_HI);
    check({8'h00, q}, 16'h0000);
    $display("reset pattern and mid-run reset done");
    finish_test();
  end
endmodule
bind spfa_core spfa_core_checker #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_cpu_stall(o_cpu_stall),
  .o_chip_reset(o_chip_reset));
